// ### hdl/bai_map.vh
// Register offsets, field positions and reset values of the byte ALU block
`ifndef BAI_MAP_VH
`define BAI_MAP_VH
// Wishbone word offsets (byte addresses)
`define BAI_OFF_CMD 8'h00
`define BAI_OFF_OPER 8'h04
`define BAI_OFF_ACC 8'h08
`define BAI_OFF_PTR0 8'h0C
`define BAI_OFF_PTR1 8'h10
`define BAI_OFF_STAT 8'h14
`define BAI_OFF_RES 8'h18
`define BAI_OFF_ADDR 8'h1C
// Command register fields
`define BAI_CMD_OP_LSB 0
`define BAI_CMD_OP_MSB 2
`define BAI_CMD_DEST_BIT 3
`define BAI_CMD_FADDR_LSB 8
`define BAI_CMD_FADDR_MSB 14
`define BAI_CMD_MODE_LSB 16
`define BAI_CMD_MODE_MSB 17
`define BAI_CMD_REL_BIT 18
`define BAI_CMD_PSEL_BIT 19
`define BAI_CMD_OFS_LSB 24
`define BAI_CMD_OFS_MSB 29
// Operation codes
`define BAI_OPC_INC 3'h0
`define BAI_OPC_OR 3'h1
`define BAI_OPC_SHL 3'h2
`define BAI_OPC_SHR 3'h3
`define BAI_OPC_COPY 3'h4
`define BAI_OPC_LDI 3'h5
// Pointer update codes
`define BAI_MODE_PREINC 2'h0
`define BAI_MODE_PREDEC 2'h1
`define BAI_MODE_POSTINC 2'h2
`define BAI_MODE_POSTDEC 2'h3
// Status bits
`define BAI_ST_ZERO_BIT 0
`define BAI_ST_CARRY_BIT 1
`define BAI_ST_BUSY_BIT 2
`define BAI_ST_ERR_BIT 3
// Reset values
`define BAI_RST_ACC 8'h00
`define BAI_RST_PTR 16'h0000
`define BAI_RST_BYTE 8'h00
`define BAI_ADDR_MAX 7'h7F
`endif

// ### hdl/bai_core.v
// Byte ALU and indirect load datapath with Wishbone register slave
`timescale 1ns/1ps
`include "bai_map.vh"

// How it works
// - Increment adds one to the addressed file byte, addresses 0 to 127.
// - Destination bit 0 writes the accumulator, 1 writes the file register back.
// - OR combines accumulator and file byte, updating only the zero flag.
// - Left shift: bit 7 to carry, zero into bit 0, carry and zero updated.
// - Right shift: bit 0 to carry, zero into bit 7, carry and zero updated.
// - Copy moves the file byte to destination and updates zero; self-copy tests.
// - Copy finishes in one execute cycle.
// - Indirect load brings the pointed byte into the accumulator, updating zero.
// - Update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Pre modes address pointer plus or minus one; pointer keeps the new value.
// - Relative mode addresses pointer plus signed offset -32..31, pointer unchanged.
// - The indirect port stores nothing; it redirects to the pointer address.
// - Pointers are 16 bits and wrap at both ends.
// - Pointer stepping leaves every status flag alone.
module bai_core #(
  parameter ADDR_W = 7,
  parameter PTR_W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [PTR_W-1:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i,
  output reg zero_o,
  output reg carry_o
);

  // ****************************************
  // States
  // ****************************************
  // Opcodes 0 to 5 walk fetch, execute and write-back, three cycles in all; 6 and 7 return to idle after fetch;
  // the bus stays open meanwhile so status can be polled
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_READ = 4'b0010;
  localparam [3:0] ST_EXEC = 4'b0100;
  localparam [3:0] ST_WBACK = 4'b1000;

  reg [3:0] state_reg;
  reg [31:0] cmd_reg;
  reg [7:0] oper_reg;
  reg [7:0] acc_reg;
  reg [PTR_W-1:0] ptr_reg [0:1];
  reg [7:0] res_reg;
  reg err_reg;
  reg [PTR_W-1:0] ea_reg;

  // ****************************************
  // Command fields
  // ****************************************
  // Fields are read from the latched command, so bus traffic cannot disturb a run
  wire [2:0] opc = cmd_reg[`BAI_CMD_OP_MSB:`BAI_CMD_OP_LSB];
  wire dest_f = cmd_reg[`BAI_CMD_DEST_BIT];
  wire [ADDR_W-1:0] faddr = cmd_reg[`BAI_CMD_FADDR_MSB:`BAI_CMD_FADDR_LSB];
  wire [1:0] mode = cmd_reg[`BAI_CMD_MODE_MSB:`BAI_CMD_MODE_LSB];
  wire rel = cmd_reg[`BAI_CMD_REL_BIT];
  wire psel = cmd_reg[`BAI_CMD_PSEL_BIT];
  wire [5:0] ofs = cmd_reg[`BAI_CMD_OFS_MSB:`BAI_CMD_OFS_LSB];
  wire is_ldi = (opc == `BAI_OPC_LDI);

  // ****************************************
  // Pointer arithmetic
  // ****************************************
  // Mode bit 0 picks decrement; plain 16-bit math wraps both ways
  wire [PTR_W-1:0] cur_ptr = ptr_reg[psel];
  wire [PTR_W-1:0] ptr_up = cur_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
  wire [PTR_W-1:0] ptr_dn = cur_ptr - {{(PTR_W-1){1'b0}}, 1'b1};
  wire [PTR_W-1:0] stepped = mode[0] ? ptr_dn : ptr_up;
  // Six-bit offset is sign-extended to pointer width
  wire [PTR_W-1:0] ofs_ext = {{(PTR_W-6){ofs[5]}}, ofs};
  reg [PTR_W-1:0] ea_next;
  reg ptr_moves;
  always @* begin
    ea_next = cur_ptr;
    ptr_moves = 1'b0;
    if (rel) begin
      // Relative access never moves the pointer
      ea_next = cur_ptr + ofs_ext;
      ptr_moves = 1'b0;
    end else begin
      case (mode)
        `BAI_MODE_PREINC: begin
          ea_next = stepped;
          ptr_moves = 1'b1;
        end
        `BAI_MODE_PREDEC: begin
          ea_next = stepped;
          ptr_moves = 1'b1;
        end
        `BAI_MODE_POSTINC: begin
          ea_next = cur_ptr;
          ptr_moves = 1'b1;
        end
        `BAI_MODE_POSTDEC: begin
          ea_next = cur_ptr;
          ptr_moves = 1'b1;
        end
        default: begin
          ea_next = cur_ptr;
          ptr_moves = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // ALU
  // ****************************************
  reg [7:0] alu_res;
  reg alu_c;
  reg upd_c;
  always @* begin
    // Defaults keep the carry unless a shift claims it
    alu_res = oper_reg;
    alu_c = carry_o;
    upd_c = 1'b0;
    case (opc)
      `BAI_OPC_INC: begin
        alu_res = oper_reg + 8'h01;
      end
      `BAI_OPC_OR: begin
        alu_res = acc_reg | oper_reg;
      end
      `BAI_OPC_SHL: begin
        alu_res = {oper_reg[6:0], 1'b0};
        alu_c = oper_reg[7];
        upd_c = 1'b1;
      end
      `BAI_OPC_SHR: begin
        alu_res = {1'b0, oper_reg[7:1]};
        alu_c = oper_reg[0];
        upd_c = 1'b1;
      end
      `BAI_OPC_COPY: begin
        // Copy passes the byte through; zero is judged at write-back
        alu_res = oper_reg;
      end
      `BAI_OPC_LDI: begin
        // The loaded byte reaches the accumulator unchanged
        alu_res = oper_reg;
      end
      default: begin
        alu_res = oper_reg;
      end
    endcase
  end

  // ****************************************
  // Flag next values
  // ****************************************
  // Carry moves only on shifts; every other result leaves it standing
  wire zero_next = (alu_res == 8'h00);
  wire carry_next = upd_c ? alu_c : carry_o;

  // The ack in flight masks the same request so each access is answered once
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire bus_wr = bus_req & we_i & (state_reg == ST_IDLE);
  wire bad_op = (opc > `BAI_OPC_LDI);

  // ****************************************
  // Register write decode
  // ****************************************
  // Narrow lanes are refused so a stray byte write cannot half-load a word
  wire wr_cmd = bus_wr && (adr_i == `BAI_OFF_CMD) && (sel_i == 4'hF);
  wire wr_oper = bus_wr && (adr_i == `BAI_OFF_OPER) && sel_i[0];
  wire wr_acc = bus_wr && (adr_i == `BAI_OFF_ACC) && sel_i[0];
  wire wr_ptr0 = bus_wr && (adr_i == `BAI_OFF_PTR0) && (sel_i[1:0] == 2'h3);
  wire wr_ptr1 = bus_wr && (adr_i == `BAI_OFF_PTR1) && (sel_i[1:0] == 2'h3);

  // ****************************************
  // Sequencer and registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 32'h00000000;
      oper_reg <= `BAI_RST_BYTE;
      acc_reg <= `BAI_RST_ACC;
      ptr_reg[0] <= `BAI_RST_PTR;
      ptr_reg[1] <= `BAI_RST_PTR;
      res_reg <= `BAI_RST_BYTE;
      err_reg <= 1'b0;
      ea_reg <= `BAI_RST_PTR;
      zero_o <= 1'b0;
      carry_o <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= `BAI_RST_PTR;
      mem_wdata_o <= `BAI_RST_BYTE;
    end else begin
      // Memory strobes are one-cycle pulses unless a state raises them
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // A command write starts a run; register loads are taken only while idle
          if (wr_cmd) begin
            cmd_reg <= dat_i;
            err_reg <= 1'b0;
            state_reg <= ST_READ;
          end
          if (wr_oper) begin
            oper_reg <= dat_i[7:0];
          end
          if (wr_acc) begin
            acc_reg <= dat_i[7:0];
          end
          if (wr_ptr0) begin
            ptr_reg[0] <= dat_i[PTR_W-1:0];
          end
          if (wr_ptr1) begin
            ptr_reg[1] <= dat_i[PTR_W-1:0];
          end
        end
        ST_READ: begin
          // Indirect port has no storage; fetch through the pointer
          mem_req_o <= 1'b1;
          if (is_ldi) begin
            mem_addr_o <= ea_next;
            // Keep the address for software to read back
            ea_reg <= ea_next;
            if (ptr_moves) begin
              ptr_reg[psel] <= stepped;
            end
          end else begin
            mem_addr_o <= {{(PTR_W-ADDR_W){1'b0}}, faddr};
          end
          state_reg <= bad_op ? ST_IDLE : ST_EXEC;
          err_reg <= bad_op;
          if (bad_op) begin
            mem_req_o <= 1'b0;
          end
        end
        ST_EXEC: begin
          // One execute cycle per operation
          oper_reg <= mem_rdata_i;
          state_reg <= ST_WBACK;
        end
        ST_WBACK: begin
          // Result and flags land together; file write-back only for destination 1
          res_reg <= alu_res;
          zero_o <= zero_next;
          if (upd_c) begin
            carry_o <= carry_next;
          end
          if (is_ldi || !dest_f) begin
            acc_reg <= alu_res;
          end else begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= {{(PTR_W-ADDR_W){1'b0}}, faddr};
            mem_wdata_o <= alu_res;
          end
          state_reg <= ST_IDLE;
        end
        default: begin
          // A corrupted state word falls back to idle rather than writing memory
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  // Busy covers every state but idle, so a poll never sees a half-done result
  wire busy_now = (state_reg != ST_IDLE);
  wire [31:0] stat_word = {28'h0000000, err_reg, busy_now, carry_o, zero_o};

  // ****************************************
  // Read multiplexer
  // ****************************************
  // Unmapped offsets read as zero so software can probe the map safely
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (adr_i)
      `BAI_OFF_CMD: begin
        rd_mux = cmd_reg;
      end
      `BAI_OFF_OPER: begin
        rd_mux = {24'h000000, oper_reg};
      end
      `BAI_OFF_ACC: begin
        rd_mux = {24'h000000, acc_reg};
      end
      `BAI_OFF_PTR0: begin
        rd_mux = {{(32-PTR_W){1'b0}}, ptr_reg[0]};
      end
      `BAI_OFF_PTR1: begin
        rd_mux = {{(32-PTR_W){1'b0}}, ptr_reg[1]};
      end
      `BAI_OFF_STAT: begin
        rd_mux = stat_word;
      end
      `BAI_OFF_RES: begin
        rd_mux = {24'h000000, res_reg};
      end
      `BAI_OFF_ADDR: begin
        rd_mux = {{(32-PTR_W){1'b0}}, ea_reg};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Writes to a busy core are acked but dropped; software polls busy first
  // Read data stands only in the ack cycle; the bus sees zero otherwise
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      dat_o <= 32'h00000000;
      if (bus_req && !we_i) begin
        dat_o <= rd_mux;
      end
    end
  end

endmodule // bai_core

// ### dv/bai_mem.sv
// Data memory model on the far side of the byte ALU core
`timescale 1ns/1ps
module bai_mem (
  input wire clk_i,
  input wire req_i,
  input wire we_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  output wire [7:0] rdata_o
);
  // Only 256 bytes: high pointer bits alias onto the low page
  reg [7:0] mem_arr [0:255];
  integer i;
  initial begin
    for (i = 0; i < 256; i = i + 1) mem_arr[i] = i[7:0] ^ 8'hA5;
  end
  // The core takes the byte in its request cycle; outside it the byte is inverted so a late sample fails
  assign rdata_o = (req_i && !we_i) ? mem_arr[addr_i[7:0]] : ~mem_arr[addr_i[7:0]];
  always @(posedge clk_i) begin
    if (req_i && we_i) mem_arr[addr_i[7:0]] <= wdata_i;
  end
endmodule // bai_mem

// ### dv/bai_chk_assertions.sv
// Port-level assertions for the byte ALU core
`timescale 1ns/1ps
module bai_chk #(
  parameter PTR_W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire mem_req_o,
  input wire mem_we_o,
  input wire [PTR_W-1:0] mem_addr_o,
  input wire [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i,
  input wire zero_o,
  input wire carry_o
);
  // Conservative busy window, so a command refused while busy is never watched
  reg [2:0] bsy_reg;
  wire go = cyc_i & stb_i & we_i & !ack_o & (adr_i == 8'h00) & (sel_i == 4'hF) & (bsy_reg == 3'h0);
  wire [2:0] op = dat_i[2:0];
  always @(posedge clk_i) begin
    if (rst_i) bsy_reg <= 3'h0;
    else if (go) bsy_reg <= 3'h5;
    else if (bsy_reg != 3'h0) bsy_reg <= bsy_reg - 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_fetch;
    ##2 (mem_req_o && !mem_we_o) ##2 1'b1;
  endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  a_file_addr: assert property (go && op < 3'h5 |-> ##2 mem_addr_o == $past(dat_i[14:8], 2))
    else $error("file address wrong");
  a_zero_wback: assert property (mem_req_o && mem_we_o |-> zero_o == (mem_wdata_o == 8'h00))
    else $error("zero flag disagrees with result");
  a_inc_wback: assert property (go && op == 3'h0 && dat_i[3] |-> s_fetch ##0
    (mem_we_o && mem_wdata_o == $past(mem_rdata_i, 2) + 8'h01)) else $error("increment result wrong");
  a_shl_flags: assert property (go && op == 3'h2 |-> s_fetch ##0 (carry_o == $past(mem_rdata_i[7], 2)
    && zero_o == ($past(mem_rdata_i[6:0], 2) == 7'h00))) else $error("left shift flags wrong");
  a_shr_flags: assert property (go && op == 3'h3 |-> s_fetch ##0 (carry_o == $past(mem_rdata_i[0], 2)
    && zero_o == ($past(mem_rdata_i[7:1], 2) == 7'h00))) else $error("right shift flags wrong");
  a_copy_flags: assert property (go && op == 3'h4 |-> s_fetch ##0
    (zero_o == ($past(mem_rdata_i, 2) == 8'h00) && $stable(carry_o))) else $error("copy flags wrong");
endmodule // bai_chk
bind bai_core bai_chk #(.PTR_W(PTR_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .mem_rdata_i(mem_rdata_i), .zero_o(zero_o), .carry_o(carry_o));

// ### dv/testbench.sv
// Self-checking bench for the byte ALU core
`timescale 1ns/1ps
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin n_fail = n_fail + 1; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] dat = 32'h0;
  reg [31:0] q;
  reg [15:0] p, ea, nx;
  wire [31:0] dat_o;
  wire ack, req, mwe, zero, carry;
  wire [15:0] maddr;
  wire [7:0] wdata, rdata;
  integer n_fail = 0, check_count = 0, k;
  initial forever #4 clk_i = ~clk_i;
  bai_core uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .mem_req_o(req), .mem_we_o(mwe),
    .mem_addr_o(maddr), .mem_wdata_o(wdata), .mem_rdata_i(rdata), .zero_o(zero), .carry_o(carry));
  bai_mem m (.clk_i(clk_i), .req_i(req), .we_i(mwe), .addr_i(maddr), .wdata_i(wdata), .rdata_o(rdata));
  task wrap_up;
    begin
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Holds the request until ack is sampled, then idles one cycle
  task wb(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      i = 0;
      do begin
        @(posedge clk_i);
        i = i + 1;
      end while (ack !== 1'b1 && i < 9);
      q = dat_o;
      if (ack !== 1'b1) begin n_fail = n_fail + 1; wrap_up; end
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin wb(1'b0, a, 32'h0); `CHK(q, e) end
  endtask
  task ex(input [2:0] op, input d, input [6:0] fa, input [1:0] mm, input rel, input ps, input [5:0] of);
    integer i;
    begin
      wb(1'b1, 8'h00, {2'h0, of, 4'h0, ps, rel, mm, 1'b0, fa, 4'h0, d, op});
      i = 0;
      do begin wb(1'b0, 8'h14, 32'h0); i = i + 1; end while (q[2] !== 1'b0 && i < 9);
      if (q[2] !== 1'b0) begin n_fail = n_fail + 1; wrap_up; end
    end
  endtask
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h20, 32'h0);
    ex(3'h0, 1'b1, 7'h7F, 2'h0, 1'b0, 1'b0, 6'h00);
    `CHK(m.mem_arr[127], 8'hDB)
    wb(1'b1, 8'h08, 32'h0F);
    ex(3'h1, 1'b0, 7'h10, 2'h0, 1'b0, 1'b0, 6'h00);
    rd(8'h08, 32'hBF);
    `CHK(m.mem_arr[16], 8'hB5)
    rd(8'h14, 32'h0);
    ex(3'h2, 1'b0, 7'h01, 2'h0, 1'b0, 1'b0, 6'h00);
    rd(8'h08, 32'h48);
    rd(8'h14, 32'h2);
    ex(3'h3, 1'b1, 7'h24, 2'h0, 1'b0, 1'b0, 6'h00);
    `CHK(m.mem_arr[36], 8'h40)
    rd(8'h14, 32'h2);
    m.mem_arr[18] = 8'h00;
    ex(3'h4, 1'b1, 7'h12, 2'h0, 1'b0, 1'b0, 6'h00);
    rd(8'h14, 32'h3);
    `CHK(m.mem_arr[18], 8'h00)
    ex(3'h4, 1'b0, 7'h7F, 2'h0, 1'b0, 1'b0, 6'h00);
    rd(8'h08, 32'hDB);
    wb(1'b1, 8'h0C, 32'hFFFF);
    p = 16'hFFFF;
    for (k = 0; k < 4; k = k + 1) begin
      nx = k[0] ? p - 16'h1 : p + 16'h1;
      ea = k[1] ? p : nx;
      ex(3'h5, 1'b0, 7'h00, k[1:0], 1'b0, 1'b0, 6'h00);
      rd(8'h1C, {16'h0, ea});
      rd(8'h0C, {16'h0, nx});
      rd(8'h08, {24'h0, ea[7:0] ^ 8'hA5});
      rd(8'h14, 32'h2);
      p = nx;
    end
    wb(1'b1, 8'h10, 32'hC5);
    ex(3'h5, 1'b0, 7'h00, 2'h0, 1'b1, 1'b1, 6'h20);
    rd(8'h1C, 32'hA5);
    rd(8'h14, 32'h3);
    ex(3'h5, 1'b0, 7'h00, 2'h3, 1'b1, 1'b1, 6'h1F);
    rd(8'h1C, 32'hE4);
    rd(8'h10, 32'hC5);
    rd(8'h08, 32'h41);
    rd(8'h18, 32'h41);
    `CHK({zero, carry}, 2'b01)
    ex(3'h6, 1'b0, 7'h00, 2'h0, 1'b0, 1'b0, 6'h00);
    rd(8'h14, 32'hA);
    rd(8'h08, 32'h41);
    wrap_up;
  end
endmodule // testbench
